// File: shared/dcf_defines.vh
/*
 Constants for the 18-bit pin-sampled FIFO block: register offsets,
 field positions, reset values. Included by verilog/dcf_fifo.v.
*/
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

`define DCF_DATA_W          18
`define DCF_DEPTH           64
`define DCF_ADDR_W          6

`define DCF_REG_CTRL        32'h0000_0000
`define DCF_REG_STATUS      32'h0000_0004
`define DCF_REG_OFFSET      32'h0000_0008

`define DCF_CTRL_ASYNC_BIT  0
`define DCF_CTRL_HEAD_BIT   1
`define DCF_CTRL_DEPTH_BIT  2
`define DCF_CTRL_RESET      3'h0

`define DCF_ST_EMPTY_N_BIT  0
`define DCF_ST_AEMPTY_N_BIT 1
`define DCF_ST_HALF_BIT     2
`define DCF_ST_AFULL_N_BIT  3
`define DCF_ST_FULL_N_BIT   4
`define DCF_ST_WTOK_BIT     5
`define DCF_ST_RTOK_BIT     6
`define DCF_ST_LEVEL_LSB    16

`define DCF_AE_OFF_RESET    7
`define DCF_AF_OFF_RESET    7

`define DCF_HTRANS_NONSEQ   2'h2

`endif

// File: verilog/dcf_fifo.v
/*
 Pin-sampled 18-bit FIFO with status flags, programmable offsets,
 retransmit and depth cascading, plus an AHB-Lite control slave.
 Assumes write and read clocks arrive as pins much slower than hclk;
 all pin inputs are synchronised by two flip-flops before use.
*/
// Design decisions made here: the register addresses and the AHB-Lite slave port.
// Overview of operation
// - Depth is a parameter: 64, 256, 512, 1K, 2K or 4K words of 18 bits.
// - Write data input and read data output are each 18 bits wide.
// - Enabled write clock rising edge stores the word on the write bus.
// - Held write enable stores one word every write clock cycle, no gaps.
// - Read port mirrors write port with its own clock and enable.
// - Writes and reads run simultaneously with unrelated clocks.
// - Works with the two clocks tied together or independent.
// - Active-low output enable controls driving of the read bus.
// - A retransmit strobe input is usable in standalone operation.
// - Flags give empty, almost empty, half full, almost full, full.
// - Almost thresholds are programmable values held inside.
// - Empty flag changes only on read clock edges.
// - Full flag changes only on write clock edges.
// - Empty and full hold steady a whole own-clock cycle.
// - Sync select low registers almost flags to their clocks, else asynchronous.
// - Half-full shares the write cascade output when standalone.
// - In depth mode the shared output carries the write cascade token.
// - Writes when full and reads when empty are ignored.
// - Empty and full flags are active low.
// - Offset load low makes writes load offsets and reads return them.
`timescale 1ns/1ns
`include "dcf_defines.vh"

module dcf_fifo #(
   parameter DATA_W = `DCF_DATA_W,
   parameter DEPTH  = `DCF_DEPTH,
   parameter ADDR_W = `DCF_ADDR_W
) (
   input  wire              hclk,
   input  wire              hresetn,
   input  wire              hsel,
   input  wire [31:0]       haddr,
   input  wire [1:0]        htrans,
   input  wire              hwrite,
   input  wire [2:0]        hsize,
   input  wire [31:0]       hwdata,
   input  wire              hready,
   output reg               hreadyout,
   output reg  [31:0]       hrdata,
   output reg               hresp,
   input  wire              write_clk,
   input  wire              write_en_n,
   input  wire [DATA_W-1:0] write_data,
   input  wire              read_clk,
   input  wire              read_en_n,
   input  wire              output_en_n,
   input  wire              offset_load_n,
   input  wire              retransmit_strobe,
   input  wire              write_cascade_in,
   input  wire              read_cascade_in,
   output reg  [DATA_W-1:0] read_data,
   output reg               read_data_oe_n,
   output reg               empty_flag_n,
   output reg               full_flag_n,
   output reg               almost_empty_flag_n,
   output reg               almost_full_flag_n,
   output reg               half_full_flag,
   output reg               read_cascade_out
);

   function [ADDR_W:0] to_gray;
      input [ADDR_W:0] b;
      begin
         to_gray = b ^ (b >> 1);
      end
   endfunction

   function [ADDR_W:0] from_gray;
      input [ADDR_W:0] g;
      integer i;
      begin
         from_gray[ADDR_W] = g[ADDR_W];
         for (i = ADDR_W - 1; i >= 0; i = i - 1)
            from_gray[i] = from_gray[i + 1] ^ g[i];
      end
   endfunction

   localparam [ADDR_W:0] DEPTH_C = DEPTH;
   localparam [ADDR_W:0] HALF_C  = DEPTH / 2;
   localparam [ADDR_W-1:0] AE_RST_C = `DCF_AE_OFF_RESET;
   localparam [ADDR_W-1:0] AF_RST_C = `DCF_AF_OFF_RESET;
   localparam NPIN = 9 + DATA_W;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the third stage only serves clock edge detection
   reg  [NPIN-1:0]   pin_s1_q;
   reg  [NPIN-1:0]   pin_s2_q;
   reg               wclk_s3_q;
   reg               rclk_s3_q;
   wire [NPIN-1:0]   pin_raw;

   assign pin_raw = {write_data, read_cascade_in, write_cascade_in, retransmit_strobe,
                     offset_load_n, output_en_n, read_en_n, write_en_n, read_clk,
                     write_clk};

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_s1_q  <= {NPIN{1'b1}};
         pin_s2_q  <= {NPIN{1'b1}};
         wclk_s3_q <= 1'b1;
         rclk_s3_q <= 1'b1;
      end
      else
      begin
         pin_s1_q  <= pin_raw;
         pin_s2_q  <= pin_s1_q;
         wclk_s3_q <= pin_s2_q[0];
         rclk_s3_q <= pin_s2_q[1];
      end
   end

   wire              wr_edge  = pin_s2_q[0] & ~wclk_s3_q;
   wire              rd_edge  = pin_s2_q[1] & ~rclk_s3_q;
   wire              wen_n_s  = pin_s2_q[2];
   wire              ren_n_s  = pin_s2_q[3];
   wire              oe_n_s   = pin_s2_q[4];
   wire              ld_n_s   = pin_s2_q[5];
   wire              rt_s     = pin_s2_q[6];
   wire              wxi_n_s  = pin_s2_q[7];
   wire              rxi_n_s  = pin_s2_q[8];
   wire [DATA_W-1:0] wdata_s  = pin_s2_q[NPIN-1:9];

   ////////////////////////////////////////////////////////////////////////
   // Control register and AHB-Lite slave, zero wait states
   reg  [2:0]        ctrl_q;
   reg               dp_wr_q;
   reg  [31:0]       dp_addr_q;
   reg  [ADDR_W-1:0] ae_off_q;
   reg  [ADDR_W-1:0] af_off_q;
   wire              async_flags = ctrl_q[`DCF_CTRL_ASYNC_BIT];
   wire              chain_head  = ctrl_q[`DCF_CTRL_HEAD_BIT];
   wire              depth_mode  = ctrl_q[`DCF_CTRL_DEPTH_BIT];
   wire              ap_valid    = hsel & hready & (htrans == `DCF_HTRANS_NONSEQ);
   wire              ctrl_wr     = dp_wr_q & (dp_addr_q == `DCF_REG_CTRL);

   ////////////////////////////////////////////////////////////////////////
   // Write side: storage, pointers, full flag, write token
   reg  [DATA_W-1:0] mem [0:DEPTH-1];
   reg  [ADDR_W:0]   wptr_q;
   reg  [ADDR_W:0]   wgray_q;
   reg  [ADDR_W:0]   rgray_w1_q;
   reg  [ADDR_W:0]   rgray_w2_q;
   reg               ld_sel_w_q;
   reg               wtok_q;
   reg               wxo_n_q;
   reg  [ADDR_W:0]   rptr_q;
   reg  [ADDR_W:0]   rgray_q;
   reg  [ADDR_W:0]   wgray_r1_q;
   reg  [ADDR_W:0]   wgray_r2_q;
   reg               ld_sel_r_q;
   reg               rtok_q;

   wire              w_active = ~depth_mode | wtok_q;
   wire              r_active = ~depth_mode | rtok_q;
   wire              do_write = wr_edge & ld_n_s & ~wen_n_s & full_flag_n & w_active;
   wire [ADDR_W:0]   wptr_d   = do_write ? wptr_q + 1'b1 : wptr_q;
   wire [ADDR_W:0]   rbin_w   = from_gray(rgray_w2_q);
   wire [ADDR_W:0]   wlevel_d = wptr_d - rbin_w;

   always @(posedge hclk)
   begin
      if (do_write)
         mem[wptr_q[ADDR_W-1:0]] <= wdata_s;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wptr_q      <= {(ADDR_W+1){1'b0}};
         wgray_q     <= {(ADDR_W+1){1'b0}};
         rgray_w1_q  <= {(ADDR_W+1){1'b0}};
         rgray_w2_q  <= {(ADDR_W+1){1'b0}};
         full_flag_n <= 1'b1;
         ld_sel_w_q  <= 1'b0;
         ae_off_q    <= AE_RST_C;
         af_off_q    <= AF_RST_C;
         wtok_q      <= 1'b1;
         wxo_n_q     <= 1'b1;
      end
      else
      begin
         if (ctrl_wr)
            wtok_q <= ~hwdata[`DCF_CTRL_HEAD_BIT];
         else if (wr_edge)
         begin
            if (do_write & depth_mode & (wptr_d[ADDR_W-1:0] == {ADDR_W{1'b0}}))
               wtok_q <= 1'b0;
            else if (~wxi_n_s)
               wtok_q <= 1'b1;
         end
         if (wr_edge)
         begin
            wptr_q      <= wptr_d;
            wgray_q     <= to_gray(wptr_d);
            rgray_w1_q  <= rgray_q;
            rgray_w2_q  <= rgray_w1_q;
            full_flag_n <= (wlevel_d != DEPTH_C);
            wxo_n_q     <= ~(do_write & depth_mode &
                             (wptr_d[ADDR_W-1:0] == {ADDR_W{1'b0}}));
            if (~ld_n_s & ~wen_n_s)
            begin
               ld_sel_w_q <= ~ld_sel_w_q;
               if (ld_sel_w_q)
                  af_off_q <= wdata_s[ADDR_W-1:0];
               else
                  ae_off_q <= wdata_s[ADDR_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read side: pointer, retransmit, empty flag, read token
   wire              do_read  = rd_edge & ld_n_s & ~rt_s & ~ren_n_s & empty_flag_n &
                                r_active;
   wire [ADDR_W:0]   rptr_d   = rt_s ? {(ADDR_W+1){1'b0}} :
                                do_read ? rptr_q + 1'b1 : rptr_q;
   wire [ADDR_W:0]   wbin_r   = from_gray(wgray_r2_q);
   wire [ADDR_W:0]   rlevel_d = wbin_r - rptr_d;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rptr_q           <= {(ADDR_W+1){1'b0}};
         rgray_q          <= {(ADDR_W+1){1'b0}};
         wgray_r1_q       <= {(ADDR_W+1){1'b0}};
         wgray_r2_q       <= {(ADDR_W+1){1'b0}};
         empty_flag_n     <= 1'b0;
         read_data        <= {DATA_W{1'b0}};
         ld_sel_r_q       <= 1'b0;
         rtok_q           <= 1'b1;
         read_cascade_out <= 1'b1;
         read_data_oe_n   <= 1'b1;
      end
      else
      begin
         read_data_oe_n <= oe_n_s;
         if (ctrl_wr)
            rtok_q <= ~hwdata[`DCF_CTRL_HEAD_BIT];
         else if (rd_edge)
         begin
            if (do_read & depth_mode & (rptr_d[ADDR_W-1:0] == {ADDR_W{1'b0}}))
               rtok_q <= 1'b0;
            else if (~rxi_n_s)
               rtok_q <= 1'b1;
         end
         if (rd_edge)
         begin
            rptr_q           <= rptr_d;
            rgray_q          <= to_gray(rptr_d);
            wgray_r1_q       <= wgray_q;
            wgray_r2_q       <= wgray_r1_q;
            empty_flag_n     <= (rlevel_d != {(ADDR_W+1){1'b0}});
            read_cascade_out <= ~(do_read & depth_mode &
                                  (rptr_d[ADDR_W-1:0] == {ADDR_W{1'b0}}));
            if (~ld_n_s & ~ren_n_s)
            begin
               ld_sel_r_q <= ~ld_sel_r_q;
               read_data  <= ld_sel_r_q ? {{(DATA_W-ADDR_W){1'b0}}, af_off_q} :
                                          {{(DATA_W-ADDR_W){1'b0}}, ae_off_q};
            end
            else if (do_read)
               read_data <= mem[rptr_q[ADDR_W-1:0]];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Almost and half flags; async mode refreshes every hclk cycle
   wire [ADDR_W:0]   lvl_now = wptr_q - rptr_q;
   wire              ae_n_r  = (rlevel_d > {1'b0, ae_off_q});
   wire              ae_n_a  = (lvl_now > {1'b0, ae_off_q});
   wire              af_n_w  = (wlevel_d < DEPTH_C - {1'b0, af_off_q});
   wire              af_n_a  = (lvl_now < DEPTH_C - {1'b0, af_off_q});

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         almost_empty_flag_n <= 1'b0;
         almost_full_flag_n  <= 1'b1;
         half_full_flag      <= 1'b0;
      end
      else
      begin
         if (async_flags)
            almost_empty_flag_n <= ae_n_a;
         else if (rd_edge)
            almost_empty_flag_n <= ae_n_r;
         if (async_flags)
            almost_full_flag_n <= af_n_a;
         else if (wr_edge)
            almost_full_flag_n <= af_n_w;
         // Shared pin: token pulse in depth mode, level otherwise
         half_full_flag <= depth_mode ? wxo_n_q : (lvl_now > HALF_C);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 32'h0000_0000;
         ctrl_q    <= `DCF_CTRL_RESET;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         dp_wr_q   <= ap_valid & hwrite;
         dp_addr_q <= haddr;
         if (ctrl_wr)
            ctrl_q <= hwdata[2:0];
         if (ap_valid & ~hwrite)
         begin
            if (haddr == `DCF_REG_CTRL)
               hrdata <= {29'h0000_0000, ctrl_q};
            else if (haddr == `DCF_REG_STATUS)
               hrdata <= {{(16-ADDR_W-1){1'b0}}, lvl_now, 9'h000, rtok_q, wtok_q,
                          full_flag_n, almost_full_flag_n, half_full_flag,
                          almost_empty_flag_n, empty_flag_n};
            else if (haddr == `DCF_REG_OFFSET)
               hrdata <= {{(16-ADDR_W){1'b0}}, af_off_q, {(16-ADDR_W){1'b0}}, ae_off_q};
            else
               hrdata <= 32'h0000_0000;
         end
      end
   end

endmodule // dcf_fifo

// File: verif/dcf_fifo_assertions.sv
/* Checker for dcf_fifo flag and port timing.
   Assumes pin clocks far slower than hclk, bound to every dcf_fifo. */
`timescale 1ns/1ns
module dcf_fifo_chk #(
   parameter DATA_W = 18
) (
   input logic              hclk,
   input logic              hresetn,
   input logic              write_clk,
   input logic              read_clk,
   input logic              output_en_n,
   input logic [DATA_W-1:0] read_data,
   input logic              read_data_oe_n,
   input logic              empty_flag_n,
   input logic              full_flag_n,
   input logic              almost_empty_flag_n,
   input logic              almost_full_flag_n,
   input logic              half_full_flag
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Pin edge must lie inside the sync window
   a_empty_read_edge:
      assert property ($changed(empty_flag_n) |-> $past(read_clk) && !$past(read_clk, 8))
      else $error("empty flag moved without a read clock edge");
   a_full_write_edge:
      assert property ($changed(full_flag_n) |-> $past(write_clk) && !$past(write_clk, 8))
      else $error("full flag moved without a write clock edge");
   a_empty_holds:
      assert property ($changed(empty_flag_n) |=> $stable(empty_flag_n) [*8])
      else $error("empty flag glitched");
   a_full_holds:
      assert property ($changed(full_flag_n) |=> $stable(full_flag_n) [*8])
      else $error("full flag glitched");
   a_oe_follows:
      assert property ($changed(output_en_n) |-> ##[2:4] read_data_oe_n == output_en_n)
      else $error("output drive did not follow enable");
   a_data_read_edge:
      assert property ($changed(read_data) |-> $past(read_clk) && !$past(read_clk, 8))
      else $error("read data moved without a read clock edge");
   a_empty_almost:
      assert property ($fell(empty_flag_n) |-> ##[0:8] !almost_empty_flag_n)
      else $error("empty without almost empty");
   a_full_half:
      assert property ($fell(full_flag_n) |-> ##[0:8] (half_full_flag && !almost_full_flag_n))
      else $error("full without half and almost full");
endmodule // dcf_fifo_chk

bind dcf_fifo dcf_fifo_chk #(.DATA_W(DATA_W)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .write_clk(write_clk), .read_clk(read_clk),
   .output_en_n(output_en_n), .read_data(read_data), .read_data_oe_n(read_data_oe_n),
   .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
   .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
   .half_full_flag(half_full_flag)
);

// File: verif/dcf_port_model.sv
/* Producer and consumer pin model for dcf_fifo.
   Assumes the bench calls push, idle_w and pop one at a time. */
`timescale 1ns/1ns
module dcf_port_model (
   output logic        write_clk,
   output logic        read_clk,
   output logic        write_en_n,
   output logic [17:0] write_data,
   output logic        read_en_n,
   input  logic [17:0] read_data
);
   logic tied;
   logic rclk_free;
   initial
   begin
      tied = 1'b0;
      write_clk = 1'b0;
      rclk_free = 1'b0;
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      write_data = 18'h0_0000;
   end
   // Odd phase offset keeps pin edges off hclk rises
   always #80 write_clk = ~write_clk;
   initial #37 forever #80 rclk_free = ~rclk_free;
   assign read_clk = tied ? write_clk : rclk_free;
   ////////////////////////////////////////////////////////////////
   task automatic push(input logic [17:0] d);
      @(negedge write_clk);
      write_en_n <= 1'b0;
      write_data <= d;
   endtask
   // Idle data is inverted so a stale word never looks valid
   task automatic idle_w();
      @(negedge write_clk);
      write_en_n <= 1'b1;
      write_data <= ~write_data;
   endtask
   task automatic pop(output logic [17:0] q);
      @(negedge read_clk);
      read_en_n <= 1'b0;
      @(negedge read_clk);
      read_en_n <= 1'b1;
      q = read_data;
   endtask
endmodule // dcf_port_model

// File: verif/tb_dual_clock_fifo_x18_flags.sv
/* Self-checking bench for dcf_fifo: AHB-Lite tasks and pin traffic.
   Assumes dcf_port_model drives the data ports at 160 ns clocks. */
`timescale 1ns/1ns
`include "dcf_defines.vh"
module tb_dual_clock_fifo_x18_flags;
   logic        hclk, hresetn, hsel, hwrite, hreadyout;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic        output_en_n, offset_load_n, retransmit_strobe, read_data_oe_n;
   logic        write_clk, read_clk, write_en_n, read_en_n;
   logic [17:0] write_data, read_data, q;
   logic        empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
   logic        half_full_flag, hresp, rco;
   int          bad_count, checked, cycles, i;
   dcf_fifo DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .write_clk(write_clk),
      .write_en_n(write_en_n), .write_data(write_data), .read_clk(read_clk),
      .read_en_n(read_en_n), .output_en_n(output_en_n), .offset_load_n(offset_load_n),
      .retransmit_strobe(retransmit_strobe), .write_cascade_in(1'b0),
      .read_cascade_in(1'b0), .read_data(read_data), .read_data_oe_n(read_data_oe_n),
      .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
      .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
      .half_full_flag(half_full_flag), .read_cascade_out(rco)
   );
   dcf_port_model u_port (
      .write_clk(write_clk), .read_clk(read_clk), .write_en_n(write_en_n),
      .write_data(write_data), .read_en_n(read_en_n), .read_data(read_data)
   );
   always #2 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   // Ready is registered, so its level at the falling edge is what the rise samples
   task automatic wait_rdy();
      @(negedge hclk);
      while (hreadyout !== 1'b1)
         @(negedge hclk);
      @(posedge hclk);
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= `DCF_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      // Taken at the closing edge; no new read phase can move it there
      rd = hrdata;
   endtask
   task automatic settle();
      repeat (4) @(negedge read_clk);
   endtask
   task automatic close_out();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         bad_count++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial
   begin
      hclk = 0;
      hresetn = 0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {output_en_n, offset_load_n} = 2'b11;
      retransmit_strobe = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("empty_n", 0, empty_flag_n);
      chk("full_n", 1, full_flag_n);
      chk("hresp", 0, hresp);
      chk("read_cascade_out", 1, rco);
      bus(0, `DCF_REG_OFFSET, 0);
      chk("offsets", 32'h0007_0007, rd);
      bus(0, `DCF_REG_STATUS, 0);
      chk("status", 32'h0000_0018, rd & 32'h0000_001F);
      bus(1, `DCF_REG_CTRL, 32'h0000_0002);
      bus(0, `DCF_REG_CTRL, 0);
      chk("ctrl", 32'h0000_0002, rd);
      bus(1, `DCF_REG_CTRL, 0);
      bus(0, 32'h0000_0010, 0);
      chk("unmapped", 0, rd);
      // Three words on held enable, then read back
      for (i = 0; i < 3; i++) u_port.push(18'h1_0000 + i);
      u_port.idle_w();
      settle();
      chk("empty_n", 1, empty_flag_n);
      for (i = 0; i < 3; i++)
      begin
         u_port.pop(q);
         chk("data", 18'h1_0000 + i, q);
      end
      settle();
      u_port.pop(q);
      chk("empty read", 18'h1_0002, q);
      @(negedge read_clk) retransmit_strobe <= 1'b1;
      @(negedge read_clk) retransmit_strobe <= 1'b0;
      settle();
      for (i = 0; i < 3; i++)
      begin
         u_port.pop(q);
         chk("replay", 18'h1_0000 + i, q);
      end
      @(posedge hclk) offset_load_n <= 1'b0;
      u_port.push(18'h0_0005);
      u_port.push(18'h0_000A);
      u_port.idle_w();
      @(posedge hclk) offset_load_n <= 1'b1;
      bus(0, `DCF_REG_OFFSET, 0);
      chk("offsets", 32'h000A_0005, rd);
      // Sixty-five writes: the last meets a full store
      for (i = 0; i < 65; i++) u_port.push(i < 64 ? 18'h2_0000 + i : 18'h3_FFFF);
      u_port.idle_w();
      settle();
      chk("full_n", 0, full_flag_n);
      chk("af_n", 0, almost_full_flag_n);
      @(posedge hclk) offset_load_n <= 1'b0;
      u_port.pop(q);
      chk("ae off", 18'h0_0005, q);
      u_port.pop(q);
      chk("af off", 18'h0_000A, q);
      @(posedge hclk) offset_load_n <= 1'b1;
      for (i = 0; i < 64; i++)
      begin
         u_port.pop(q);
         chk("fill data", 18'h2_0000 + i, q);
         if (i == 0 || i == 30 || i == 31 || i == 57 || i == 58)
         begin
            settle();
            chk("full_n", 1, full_flag_n);
            chk("half", (63 - i) > 32, half_full_flag);
            chk("ae_n", (63 - i) > 5, almost_empty_flag_n);
         end
      end
      settle();
      chk("empty_n", 0, empty_flag_n);
      @(posedge hclk) output_en_n <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("oe_n", 0, read_data_oe_n);
      u_port.tied = 1'b1;
      for (i = 0; i < 2; i++) u_port.push(18'h0_1230 + i);
      u_port.idle_w();
      settle();
      for (i = 0; i < 2; i++)
      begin
         u_port.pop(q);
         chk("tied", 18'h0_1230 + i, q);
      end
      // Asynchronous almost flags follow the level every hclk
      bus(1, `DCF_REG_CTRL, 32'h0000_0001);
      repeat (4) @(posedge hclk);
      chk("ae_n async", 0, almost_empty_flag_n);
      for (i = 0; i < 7; i++) u_port.push(18'h0_2000 + i);
      u_port.idle_w();
      settle();
      chk("ae_n async", 1, almost_empty_flag_n);
      chk("af_n async", 1, almost_full_flag_n);
      bus(1, `DCF_REG_CTRL, 0);
      close_out();
   end
endmodule // tb_dual_clock_fifo_x18_flags
